// ### core/rx_port_consts.svh
// Shared constants of the receive port device and its host controller.
`ifndef RX_PORT_CONSTS_SVH
`define RX_PORT_CONSTS_SVH
`define RXP_DATA_W      10
`define RXP_QUAL_CNT    4'h8
`define RXP_CNT_W       4
`define RXP_MASK_10     10'h3ff
`define RXP_MASK_8      10'h0ff
`define RXP_ADDR_RST    10'h000
`define RXP_MODE_RST    1'b1
`define RXP_FIFO_AW     3
`define RXP_FIFO_DEPTH  4'h8
`define RXP_RST_HOLD    4'ha
`define RXP_REG_CMD     8'h00
`define RXP_REG_WDATA   8'h04
`define RXP_REG_STATUS  8'h08
`define RXP_REG_RDATA   8'h0c
`define RXP_WD_MODE_BIT 10
`define RXP_RESP_OKAY   2'h0
`define RXP_RESP_SLVERR 2'h2
`endif

// ### core/rx_port_pkg.sv
// Types shared by the receive port device and its host controller.
package rx_port_pkg;
  // Commands that software gives the host controller.
  typedef enum logic [1:0] {
    OP_FIFO_RESET = 2'b00,
    OP_REG_WRITE  = 2'b01,
    OP_REG_READ   = 2'b10,
    OP_DATA_READ  = 2'b11
  } host_op_t;
  // Pin sequencer states of the host controller.
  typedef enum logic [2:0] {
    HS_IDLE   = 3'b000,
    HS_SETUP  = 3'b001,
    HS_HOLD   = 3'b010,
    HS_STROBE = 3'b011,
    HS_CAPT   = 3'b100,
    HS_REL    = 3'b101
  } host_state_t;
endpackage

// ### core/rx_link_if.sv
// Parallel receive interface between the host controller and the device.
`timescale 1ns/1ps
interface rx_link_if;
  logic       addr_match_n;           // Address match, active low.
  logic       rx_reset_select_n;      // Receive reset select, active low.
  logic       rx_enable_n;            // Receive enable and strobe.
  logic       rx_direction_pin;       // High reads, low writes the register.
  logic       rx_special_data_select; // Unicast when high at a write.
  logic [9:0] host_bus_out;           // Host drive of the data bus.
  logic       host_bus_oe_n;          // Host drives the bus when low.
  logic [9:0] dev_bus_out;            // Device drive of the data bus.
  logic       dev_bus_oe_n;           // Device drives the bus when low.
  logic [9:0] rx_parallel_bus;        // Resolved bus level.
  logic       empty_n;                // Empty flag, active low.
  logic       full_n;                 // Full flag, active low.
  logic       flag_oe_n;              // Flags are driven when low.

  // An undriven bus floats high, as with a pull-up.
  assign rx_parallel_bus = !dev_bus_oe_n  ? dev_bus_out :
                           !host_bus_oe_n ? host_bus_out : 10'h3ff;

  modport device (
    input  addr_match_n, rx_reset_select_n, rx_enable_n,
    input  rx_direction_pin, rx_special_data_select, rx_parallel_bus,
    output dev_bus_out, dev_bus_oe_n, empty_n, full_n, flag_oe_n
  );
  modport host (
    output addr_match_n, rx_reset_select_n, rx_enable_n,
    output rx_direction_pin, rx_special_data_select,
    output host_bus_out, host_bus_oe_n,
    input  rx_parallel_bus, empty_n, full_n, flag_oe_n
  );
endinterface

// ### core/rx_port_device.sv
// Receive port device: FIFO reset sequence and address register access.
`include "rx_port_consts.svh"
`timescale 1ns/1ps
module rx_port_device (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Link to the host controller.
  rx_link_if.device        link,
  // Static configuration.
  input  wire logic        i_ext_fifo_sel,
  input  wire logic        i_char_width_sel,
  // Receive control side that fills the FIFO.
  input  wire logic        i_push,
  input  wire logic [9:0]  i_push_data,
  output logic             o_push_ready,
  // Incoming address characters to compare.
  input  wire logic        i_addr_strobe,
  input  wire logic [9:0]  i_addr_char,
  output logic             o_addr_hit,
  // Status.
  output logic             o_fifo_reset,
  output logic             o_selected,
  output logic [9:0]       o_addr_reg
);
  import rx_port_pkg::*;

  // Pin levels decoded to active high.
  wire am       = ~link.addr_match_n;
  wire rst_sel  = ~link.rx_reset_select_n;
  wire en       = ~link.rx_enable_n;
  wire rst_cond = am & rst_sel;

  // Sampled match conditions and enable history.
  logic rst_match_q;                 // Reset-select match present.
  logic data_match_q;                // Normal data match present.
  logic en_prev_q;                   // Enable level at the last edge.
  logic [`RXP_CNT_W-1:0] cnt_q;      // Qualification counter.
  logic [`RXP_CNT_W-1:0] cnt_d;
  logic force_q;                     // Flags forced to empty.
  logic force_d;
  logic blk_q;                       // Selection refused this cycle.
  logic sel_q;                       // Selected for data transfers.
  logic rd_q;                        // Register read is being driven.
  logic [9:0] out_q;                 // Registered bus drive value.
  logic [9:0] addr_q;                // Address match register.
  logic mode_q;                      // High: unicast, low: multicast.
  logic hit_q;                       // Last address compare result.

  // FIFO storage and pointers; one spare pointer bit tells full.
  logic [9:0] mem [0:7];
  logic [`RXP_FIFO_AW:0] wr_ptr_q;
  logic [`RXP_FIFO_AW:0] rd_ptr_q;

  // Decode of events seen at the next edge.
  wire en_fall   = en & ~en_prev_q;
  wire qual      = (cnt_q == `RXP_QUAL_CNT);
  wire release_e = qual & ~rst_cond;
  wire reg_space = rst_match_q & ~i_ext_fifo_sel;
  wire reg_stb   = en_fall & reg_space;
  wire reg_wr    = reg_stb & ~link.rx_direction_pin;
  wire reg_rd    = reg_stb & link.rx_direction_pin;
  wire sel_start = en_fall & data_match_q & ~blk_q;
  wire [`RXP_FIFO_AW:0] level = wr_ptr_q - rd_ptr_q;
  wire fifo_empty = (level == {(`RXP_FIFO_AW+1){1'b0}});
  wire fifo_full  = (level == `RXP_FIFO_DEPTH);
  wire pop   = en & ~force_q & ~fifo_empty & (sel_start | sel_q);
  wire push  = i_push & o_push_ready;
  wire [9:0] mask = i_char_width_sel ? `RXP_MASK_10 : `RXP_MASK_8;
  wire [9:0] bit_eq = ~(addr_q ^ i_addr_char) & mask;
  wire hit_now = mode_q ? (bit_eq == mask) : (|bit_eq);

  // Qualification counter. It restarts whenever the reset match
  // breaks, freezes while the enable is asserted, and stops at the
  // qualifying count so that the hold can be seen.
  always_comb begin
    cnt_d = cnt_q;
    if (!rst_cond) begin
      cnt_d = '0;
    end else if (en) begin
      cnt_d = cnt_q;
    end else if (!qual) begin
      cnt_d = cnt_q + `RXP_CNT_W'(1);
    end
  end

  // Forcing of the flags. Qualification sets it, and the first new
  // character written by the receive control side removes it, which
  // is the only sign that the FIFO is usable again.
  always_comb begin
    force_d = force_q;
    if (qual) begin
      force_d = 1'b1;
    end else if (push) begin
      force_d = 1'b0;
    end
  end

  // Match conditions follow the pins as sampled at each edge.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_match_q  <= 1'b0;
      data_match_q <= 1'b0;
      en_prev_q    <= 1'b0;
    end else begin
      rst_match_q  <= rst_cond;
      data_match_q <= am & ~rst_sel;
      en_prev_q    <= en;
    end
  end

  // Reset sequence state.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      force_q <= 1'b0;
      blk_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      force_q <= force_d;
      // Only a release of the select starts the blackout cycle.
      blk_q   <= release_e & ~rst_sel;
    end
  end

  // Selection. A falling enable during the blackout is swallowed, and
  // because the enable history then reads asserted, only a fresh
  // deassert and reassert can select the device.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= 1'b0;
    end else if (!en) begin
      sel_q <= 1'b0;
    end else if (sel_start) begin
      sel_q <= 1'b1;
    end
  end

  // Register read drive lasts while the strobe stays asserted.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_q <= 1'b0;
    end else if (!en) begin
      rd_q <= 1'b0;
    end else if (reg_rd) begin
      rd_q <= 1'b1;
    end
  end

  // Bus drive value: register contents on a read, FIFO head on a pop.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= '0;
    end else if (reg_rd) begin
      out_q <= addr_q & mask;
    end else if (pop) begin
      out_q <= mem[rd_ptr_q[`RXP_FIFO_AW-1:0]];
    end
  end

  // Address register write. The value and the match mode are taken
  // together at the strobe; the upper bits are dropped in 8-bit mode.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q <= `RXP_ADDR_RST;
      mode_q <= `RXP_MODE_RST;
    end else if (reg_wr) begin
      addr_q <= link.rx_parallel_bus & mask;
      mode_q <= link.rx_special_data_select;
    end
  end

  // Address compare result, refreshed at each incoming address.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hit_q <= 1'b0;
    end else if (i_addr_strobe) begin
      hit_q <= hit_now;
    end
  end

  // FIFO pointers. The flush happens when the held reset is released,
  // not at qualification, so the FIFO is untouched until then.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (release_e) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + (`RXP_FIFO_AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + (`RXP_FIFO_AW+1)'(1);
      end
    end
  end

  // FIFO storage has no reset; only written entries are ever read.
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_q[`RXP_FIFO_AW-1:0]] <= i_push_data;
    end
  end

  // Reset pulse marks the moment the held reset goes ahead.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fifo_reset <= 1'b0;
    end else begin
      o_fifo_reset <= release_e;
    end
  end

  // Writes are refused while a qualified reset is held, since the
  // data would be thrown away by the flush that follows.
  assign o_push_ready = ~fifo_full & ~qual;

  // Bus and flag drivers.
  assign link.dev_bus_out  = out_q;
  assign link.dev_bus_oe_n = ~(sel_q | rd_q);
  assign link.flag_oe_n    = ~(data_match_q | rst_match_q);
  assign link.empty_n      = ~(force_q | fifo_empty);
  assign link.full_n       = force_q | ~fifo_full;
  assign o_addr_hit        = hit_q;
  assign o_selected        = sel_q;
  assign o_addr_reg        = addr_q;
endmodule

// ### core/rx_port_host.sv
// Host controller: AXI4-Lite command registers driving the receive pins.
`include "rx_port_consts.svh"
`timescale 1ns/1ps
module rx_port_host (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // Link to the device.
  rx_link_if.host          link,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  import rx_port_pkg::*;

  logic [7:0]  awaddr_q;           // Captured write address.
  logic        aw_have_q;          // Write address held.
  logic [31:0] wdata_q;            // Captured write data.
  logic [3:0]  wstrb_q;            // Captured byte enables.
  logic        w_have_q;           // Write data held.
  logic [10:0] wval_q;             // Value and mode for the device.
  logic [9:0]  rval_q;             // Last word read from the bus.
  host_state_t st_q;               // Pin sequencer state.
  host_op_t    op_q;               // Command in progress.
  logic [3:0]  cnt_q;              // Reset hold counter.

  wire do_wr  = aw_have_q & w_have_q & ~o_bvalid;
  wire cmd_wr = do_wr & (awaddr_q == `RXP_REG_CMD) & wstrb_q[0];
  wire start  = cmd_wr & (st_q == HS_IDLE);
  wire wr_hit = (awaddr_q == `RXP_REG_CMD) |
                (awaddr_q == `RXP_REG_WDATA);
  wire rd_hit = (i_araddr == `RXP_REG_CMD) |
                (i_araddr == `RXP_REG_WDATA) |
                (i_araddr == `RXP_REG_STATUS) |
                (i_araddr == `RXP_REG_RDATA);
  wire [31:0] status = {28'h000_0000, link.full_n, link.empty_n,
                        ~link.flag_oe_n, (st_q != HS_IDLE)};
  wire [31:0] rd_mux =
    (i_araddr == `RXP_REG_WDATA)  ? {21'h00_0000, wval_q} :
    (i_araddr == `RXP_REG_STATUS) ? status :
    (i_araddr == `RXP_REG_RDATA)  ? {22'h00_0000, rval_q} : '0;

  // Address and data are taken in either order; the response waits
  // until both have arrived.
  assign o_awready = ~aw_have_q & ~o_bvalid;
  assign o_wready  = ~w_have_q & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  // Write channel capture and response.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RXP_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= wr_hit ? `RXP_RESP_OKAY : `RXP_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: the answer follows one edge after the address.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= `RXP_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_hit ? `RXP_RESP_OKAY : `RXP_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Value register for the device, written per byte lane.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wval_q <= '0;
    end else if (do_wr && awaddr_q == `RXP_REG_WDATA) begin
      if (wstrb_q[0]) begin
        wval_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        wval_q[10:8] <= wdata_q[10:8];
      end
    end
  end

  // Pin sequencer. Every command starts and ends with the device
  // deselected, so a continuously selected link never forms.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q                        <= HS_IDLE;
      op_q                        <= OP_FIFO_RESET;
      cnt_q                       <= '0;
      rval_q                      <= '0;
      link.addr_match_n           <= 1'b1;
      link.rx_reset_select_n      <= 1'b1;
      link.rx_enable_n            <= 1'b1;
      link.rx_direction_pin       <= 1'b0;
      link.rx_special_data_select <= 1'b0;
      link.host_bus_out           <= '0;
      link.host_bus_oe_n          <= 1'b1;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (start) begin
            op_q                        <= host_op_t'(wdata_q[1:0]);
            cnt_q                       <= '0;
            link.addr_match_n           <= 1'b0;
            link.rx_reset_select_n      <= (wdata_q[1:0] == OP_DATA_READ);
            link.rx_direction_pin       <= (wdata_q[1:0] != OP_REG_WRITE);
            link.rx_special_data_select <= wval_q[`RXP_WD_MODE_BIT];
            link.host_bus_out           <= wval_q[9:0];
            link.host_bus_oe_n          <= (wdata_q[1:0] != OP_REG_WRITE);
            st_q <= (wdata_q[1:0] == OP_FIFO_RESET) ? HS_HOLD : HS_SETUP;
          end
        end
        HS_SETUP: begin
          link.rx_enable_n <= 1'b0;
          st_q             <= HS_STROBE;
        end
        HS_STROBE: begin
          link.rx_enable_n <= 1'b1;
          st_q             <= HS_CAPT;
        end
        HS_CAPT: begin
          if (op_q != OP_REG_WRITE) begin
            rval_q <= link.rx_parallel_bus;
          end
          // Reset select was held for three edges only on a register access; a data read never drives it low.
          link.rx_reset_select_n <= 1'b1;
          link.addr_match_n      <= 1'b1;
          link.host_bus_oe_n     <= 1'b1;
          st_q                   <= HS_IDLE;
        end
        HS_HOLD: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `RXP_RST_HOLD) begin
            link.rx_reset_select_n <= 1'b1;
            st_q                   <= HS_REL;
          end
        end
        HS_REL: begin
          link.addr_match_n <= 1'b1;
          st_q              <= HS_IDLE;
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// ### sim/rx_port_asserts.sv
// Checker that watches the receive link between host controller and device.
`timescale 1ns/1ps
module rx_port_asserts (
  // Clock, reset and static mode.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_fifo_sel,
  // Link signals.
  input wire logic addr_match_n,
  input wire logic rx_reset_select_n,
  input wire logic rx_enable_n,
  input wire logic rx_direction_pin,
  input wire logic host_bus_oe_n,
  input wire logic dev_bus_oe_n,
  input wire logic empty_n,
  input wire logic full_n,
  input wire logic flag_oe_n
);
  // Reset match is present while both selects are low.
  wire        hold_w = !addr_match_n && !rx_reset_select_n;
  logic [3:0] cnt_q;  // Held cycles, frozen while the enable is low.
  // The count saturates at eight so a long hold never wraps it.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 4'h0;
    end else if (!hold_w) begin
      cnt_q <= 4'h0;
    end else if (rx_enable_n && cnt_q != 4'h8) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_match_flags;
    !addr_match_n |=> !flag_oe_n;
  endproperty
  a_match_flags: assert property (p_match_flags)
    else $error("flags not driven under address match");
  property p_forced_empty;
    (cnt_q == 4'h8) && hold_w |=> !flag_oe_n && !empty_n && full_n;
  endproperty
  a_forced_empty: assert property (p_forced_empty)
    else $error("flags not forced empty after qualification");
  property p_read_drive;
    !i_ext_fifo_sel && hold_w && rx_direction_pin && !rx_enable_n
      && $past(rx_enable_n) |=> !dev_bus_oe_n;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("register read strobe left the bus undriven");
  property p_write_quiet;
    hold_w && !rx_direction_pin && !rx_enable_n |=> dev_bus_oe_n;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("device drove the bus during a register write");
  property p_ext_block;
    i_ext_fifo_sel && hold_w && !rx_enable_n |=> dev_bus_oe_n;
  endproperty
  a_ext_block: assert property (p_ext_block)
    else $error("register reached with external timing selected");
  property p_bus_release;
    addr_match_n && $past(addr_match_n) && rx_enable_n |=> dev_bus_oe_n;
  endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("device kept driving the bus while unaddressed");
  property p_no_fight;
    !dev_bus_oe_n |-> host_bus_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host and device drove the bus together");
  property p_host_strobe;
    $fell(rx_enable_n) && !rx_reset_select_n |-> !addr_match_n;
  endproperty
  a_host_strobe: assert property (p_host_strobe)
    else $error("register strobe without address match");
  property p_blackout;
    $rose(rx_reset_select_n) && cnt_q == 4'h8 && !addr_match_n
      ##1 $fell(rx_enable_n) |=> dev_bus_oe_n;
  endproperty
  a_blackout: assert property (p_blackout)
    else $error("selection accepted in the cycle after reset release");
endmodule

// ### sim/tb_rx_fifo_reset_and_addr_reg_access.sv
// Testbench driving the host controller over AXI4-Lite against the device.
`timescale 1ns/1ps
`include "rx_port_consts.svh"
module tb_rx_fifo_reset_and_addr_reg_access;
  import rx_port_pkg::*;
  logic        i_sys_clk, i_rst_n, ext_sel, width_sel, push, addr_strobe;
  logic [9:0]  push_data, addr_char;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  r;
  wire         push_ready, addr_hit, fifo_reset, selected;
  wire  [9:0]  addr_reg;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          err_total, check_count, flush_cnt, sel_cnt;
  logic [9:0]  chars [3] = '{10'h155, 10'h154, 10'h2aa};  // Probe set.
  rx_link_if link();
  rx_port_device u_rx_port_device (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .link(link), .i_ext_fifo_sel(ext_sel),
    .i_char_width_sel(width_sel), .i_push(push), .i_push_data(push_data),
    .o_push_ready(push_ready), .i_addr_strobe(addr_strobe),
    .i_addr_char(addr_char), .o_addr_hit(addr_hit),
    .o_fifo_reset(fifo_reset), .o_selected(selected),
    .o_addr_reg(addr_reg));
  rx_port_host u_rx_port_host (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .link(link), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  rx_port_asserts u_rx_port_asserts (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_ext_fifo_sel(ext_sel),
    .addr_match_n(link.addr_match_n),
    .rx_reset_select_n(link.rx_reset_select_n),
    .rx_enable_n(link.rx_enable_n),
    .rx_direction_pin(link.rx_direction_pin),
    .host_bus_oe_n(link.host_bus_oe_n), .dev_bus_oe_n(link.dev_bus_oe_n),
    .empty_n(link.empty_n), .full_n(link.full_n),
    .flag_oe_n(link.flag_oe_n));
  // Free-running 250 MHz clock.
  always #2 i_sys_clk = ~i_sys_clk;
  // Flush pulses and selected cycles are counted so that missing or
  // extra ones show up; a data read selects for exactly one cycle.
  always @(posedge i_sys_clk) begin
    if (fifo_reset === 1'b1) begin
      flush_cnt <= flush_cnt + 1;
    end
    if (selected === 1'b1) begin
      sel_cnt <= sel_cnt + 1;
    end
  end
  // Compares one result word and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One AXI4-Lite write; address and data are offered together.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  // One AXI4-Lite read; data and response are taken at the handshake.
  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    v = rdata;
    r = rresp;
  endtask
  // Issues a command and polls status until the controller is idle.
  task automatic run_op(input host_op_t op);
    axi_wr(`RXP_REG_CMD, {30'h0000_0000, op});
    do axi_rd(`RXP_REG_STATUS); while (v[0] !== 1'b0);
  endtask
  // Writes the address register with its match mode.
  task automatic reg_wr(input logic [9:0] val, input logic uni);
    axi_wr(`RXP_REG_WDATA, {21'h00_0000, uni, val});
    run_op(OP_REG_WRITE);
  endtask
  // Pushes one word from the receive control side.
  task automatic push_word(input logic [9:0] d);
    @(posedge i_sys_clk);
    push      <= 1'b1;
    push_data <= d;
    do @(posedge i_sys_clk); while (push_ready !== 1'b1);
    push <= 1'b0;
  endtask
  // Presents one address character and checks the hit result.
  task automatic addr_cmp(input logic [9:0] c, input logic exp);
    @(posedge i_sys_clk);
    addr_strobe <= 1'b1;
    addr_char   <= c;
    @(posedge i_sys_clk);
    addr_strobe <= 1'b0;
    @(posedge i_sys_clk);
    chk(32'(addr_hit), 32'(exp));
  endtask
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hang beyond the expected run length ends the test as a failure.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    {i_sys_clk, i_rst_n, ext_sel, push, addr_strobe} = 5'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {width_sel, wstrb} = 5'h1f;
    {push_data, addr_char, awaddr, araddr, wdata} = 68'h0;
    {err_total, check_count, flush_cnt, sel_cnt} = 128'h0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    chk(32'(addr_reg), 32'h0000_0000);
    run_op(OP_REG_READ);
    axi_rd(`RXP_REG_RDATA);
    chk(v & 32'h0000_03ff, 32'h0000_0000);
    axi_rd(8'h10);
    chk(32'(r), 32'(`RXP_RESP_SLVERR));
    axi_wr(8'h20, 32'h0000_0001);
    chk(32'(r), 32'(`RXP_RESP_SLVERR));
    $display("test reset_and_map done");
    push_word(10'h2a5);
    push_word(10'h15a);
    // Both match modes; expected hits are worked out bit by bit.
    for (int m = 1; m >= 0; m--) begin
      reg_wr(10'h155, m[0]);
      chk(32'(addr_reg), 32'h0000_0155);
      for (int k = 0; k < 3; k++) begin
        addr_cmp(chars[k], m[0] ? chars[k] == 10'h155
                                : |(~(chars[k] ^ 10'h155)));
      end
    end
    run_op(OP_REG_READ);
    axi_rd(`RXP_REG_RDATA);
    chk(v & 32'h0000_03ff, 32'h0000_0155);
    run_op(OP_DATA_READ);
    axi_rd(`RXP_REG_RDATA);
    chk(v & 32'h0000_03ff, 32'h0000_02a5);
    chk(flush_cnt, 0);
    $display("test register_access done");
    ext_sel <= 1'b1;
    reg_wr(10'h0aa, 1'b1);
    chk(32'(addr_reg), 32'h0000_0155);
    ext_sel   <= 1'b0;
    width_sel <= 1'b0;
    reg_wr(10'h3a5, 1'b1);
    run_op(OP_REG_READ);
    axi_rd(`RXP_REG_RDATA);
    chk(v & 32'h0000_03ff, 32'h0000_00a5);
    chk(32'(addr_reg), 32'h0000_00a5);
    width_sel <= 1'b1;
    $display("test mode_and_width done");
    // Qualification is checked mid-hold, one edge before the host lets go.
    axi_wr(`RXP_REG_CMD, {30'h0000_0000, OP_FIFO_RESET});
    repeat (9) @(posedge i_sys_clk);
    chk(32'(push_ready), 32'h0000_0000);
    chk(flush_cnt, 0);
    // Still held: busy, flags driven, empty forced although data waits.
    axi_rd(`RXP_REG_STATUS);
    chk(v & 32'h0000_000f, 32'h0000_000b);
    do axi_rd(`RXP_REG_STATUS); while (v[0] !== 1'b0);
    chk(flush_cnt, 1);
    push_word(10'h2c3);
    run_op(OP_DATA_READ);
    axi_rd(`RXP_REG_RDATA);
    chk(v & 32'h0000_03ff, 32'h0000_02c3);
    chk(sel_cnt, 2);
    $display("test fifo_reset done");
    end_of_test();
  end
endmodule
